// >>> design/tsep_device.sv
/*
  Memory end of the three-wire serial word port: instruction framing, read stream,
  enable latch, timed programming with busy, status mode on data out.
  Assumes the link pins come from another clock domain and are sampled by i_clk.
*/
// Overview of operation
// - frame: opcode, ten-bit address, data word
// - select fall with clock high starts instruction
// - select rise abandons instruction
// - sample data on clock rise, shift on fall
// - select fall with clock low: status output
// - data out released unless reading or status
// - ready low only while programming
// - instructions ignored while programming
// - write, read, enable, disable opcode encodings
// - host never issues factory fill opcode
// - write programs after thirty-second clock rise
// - powers up disabled; enable, disable latch
// - read, enable, disable ignore enable and reset
// - write reset high blocks write
// - write reset high aborts programming
// - host deselects before next instruction after abort
// - select and clock may idle while busy
// - host keeps select high 250ns between
// - seventeenth clock fall starts word, msb first
// - stream continues, address wraps 3ff to 000
// - array of 1024 sixteen-bit words
`timescale 1ns/1ps
module tsep_device import tsep_pkg::*; #(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DFLT
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // link
  tsep_if.dev link,
  // local status
  output logic o_prog_enabled,
  output logic o_busy
);
  localparam logic [PROG_CNT_W-1:0] PROG_LAST = PROG_CNT_W'(PROG_CYCLES - 1);

  typedef struct packed {
    tsep_dev_st_e st;
    logic sel_q;
    logic clk_q;
    logic [31:0] sh;
    logic [5:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] word;
    logic [3:0] bit_ix;
    logic out;
    logic oe;
    logic ready;
    logic enabled;
    logic busy;
    logic [PROG_CNT_W-1:0] timer;
    logic [ADDR_W-1:0] wr_addr;
    logic [WORD_W-1:0] wr_data;
    logic [DEPTH-1:0][WORD_W-1:0] mem;
  } tsep_dev_s;

  tsep_dev_s r;
  tsep_dev_s n;
  logic [3:0] pins_s;
  logic sel_s;
  logic sk_s;
  logic di_s;
  logic rst_s;
  logic sk_rise;
  logic sk_fall;
  logic sel_fall;
  logic sel_rise;

  tsep_sync #(.WIDTH(4), .RST_VAL(DEV_SYNC_RST)) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_d({link.sel_n, link.serial_clock_in, link.serial_data_in, link.prog_reset}),
    .o_q(pins_s)
  );

  assign {sel_s, sk_s, di_s, rst_s} = pins_s;
  assign sk_rise = sk_s & ~r.clk_q;
  assign sk_fall = ~sk_s & r.clk_q;
  assign sel_fall = ~sel_s & r.sel_q;
  assign sel_rise = sel_s & ~r.sel_q;

  always_comb begin
    n = r;
    n.sel_q = sel_s;
    n.clk_q = sk_s;
    // self-timed programming
    if (r.busy) begin
      if (rst_s) begin
        n.busy = 1'b0;
      end else if (r.timer == PROG_LAST) begin
        n.busy = 1'b0;
        n.mem[r.wr_addr] = r.wr_data;
      end else begin
        n.timer = PROG_CNT_W'(r.timer + 1'b1);
      end
    end
    case (r.st)
      DEV_IDLE: begin
        n.oe = 1'b0;
      end
      DEV_STATUS: begin
        n.oe = 1'b1;
        n.out = ~n.busy;
        if (sk_rise && di_s) begin
          n.oe = 1'b0;
          n.sh = 32'h0000_0001;
          n.cnt = 6'h01;
          n.st = r.busy ? DEV_HOLD : DEV_CMD;
        end
      end
      DEV_CMD: begin
        if (sk_rise) begin
          n.sh = {r.sh[30:0], di_s};
          n.cnt = 6'(r.cnt + 1'b1);
          if (n.cnt == HDR_BITS) begin
            if (n.sh[15:10] == OP_READ_HI) begin
              n.addr = n.sh[ADDR_W-1:0];
              n.word = r.mem[n.sh[ADDR_W-1:0]];
              n.bit_ix = 4'h0;
              n.st = DEV_READ;
            end else if (n.sh[15:8] == OP_ENABLE) begin
              n.enabled = 1'b1;
              n.st = DEV_HOLD;
            end else if (n.sh[15:8] == OP_DISABLE) begin
              n.enabled = 1'b0;
              n.st = DEV_HOLD;
            end else if (n.sh[15:10] != OP_WRITE_HI) begin
              n.st = DEV_HOLD;
            end
          end else if (n.cnt == WRITE_BITS) begin
            if (r.enabled && !rst_s && !r.busy) begin
              n.busy = 1'b1;
              n.timer = '0;
              n.wr_addr = n.sh[16+ADDR_W-1:16];
              n.wr_data = n.sh[WORD_W-1:0];
              n.mem[n.sh[16+ADDR_W-1:16]] = ERASED_WORD;
            end
            n.st = DEV_HOLD;
          end
        end
      end
      DEV_READ: begin
        if (sk_fall) begin
          n.oe = 1'b1;
          n.out = r.word[WORD_W-1];
          n.word = {r.word[WORD_W-2:0], 1'b0};
          n.bit_ix = 4'(r.bit_ix + 1'b1);
          if (r.bit_ix == 4'hf) begin
            n.addr = ADDR_W'(r.addr + 1'b1);
            n.word = r.mem[ADDR_W'(r.addr + 1'b1)];
          end
        end
      end
      DEV_HOLD: begin
        n.oe = 1'b0;
      end
      default: begin
        n.st = DEV_IDLE;
        n.oe = 1'b0;
      end
    endcase
    // select edges override the frame in progress
    if (sel_fall) begin
      n.cnt = 6'h00;
      if (!sk_s) begin
        n.st = DEV_STATUS;
        n.oe = 1'b1;
        n.out = ~n.busy;
      end else if (!r.busy) begin
        n.st = DEV_CMD;
        n.oe = 1'b0;
      end else begin
        n.st = DEV_HOLD;
        n.oe = 1'b0;
      end
    end else if (sel_rise) begin
      n.st = DEV_IDLE;
      n.oe = 1'b0;
    end
    n.ready = ~n.busy;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      r <= '0;
      r.sel_q <= 1'b1;
      r.clk_q <= 1'b1;
      r.ready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link.serial_data_out = r.out;
  assign link.serial_data_oe = r.oe;
  assign link.ready = r.ready;
  assign o_prog_enabled = r.enabled;
  assign o_busy = r.busy;
endmodule : tsep_device

// >>> design/tsep_host.sv
/*
  Host end of the three-wire serial word port: makes the link clock by a divider,
  frames read, write, enable, disable and status requests, collects read words.
  Assumes data out and ready arrive from another domain and are synchronised here.
*/
`timescale 1ns/1ps
module tsep_host import tsep_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // request
  input wire logic i_start,
  input wire logic [2:0] i_cmd,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [WORD_W-1:0] i_wdata,
  input wire logic i_prog_reset,
  // answer
  output logic o_idle,
  output logic o_done,
  output logic [WORD_W-1:0] o_rdata,
  output logic o_link_ready,
  // link
  tsep_if.host link
);
  typedef struct packed {
    tsep_host_st_e st;
    logic [2:0] cmd;
    logic [2:0] ph;
    logic [5:0] cnt;
    logic [5:0] len;
    logic [31:0] sh;
    logic sel_n;
    logic sclk;
    logic sdi;
    logic prst;
    logic [WORD_W-1:0] rdata;
    logic done;
    logic idle;
    logic rdy;
    logic [3:0] gap;
  } tsep_host_s;

  tsep_host_s r;
  tsep_host_s n;
  logic sdo_s;
  logic rdy_s;

  tsep_sync #(.WIDTH(2), .RST_VAL(HOST_SYNC_RST)) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_d({link.serial_data_line, link.ready}),
    .o_q({sdo_s, rdy_s})
  );

  always_comb begin
    n = r;
    n.done = 1'b0;
    n.prst = i_prog_reset;
    n.rdy = rdy_s;
    n.ph = 3'(r.ph + 1'b1);
    case (r.st)
      HOST_IDLE: begin
        n.ph = 3'h0;
        n.cnt = 6'h00;
        if (i_start && (rdy_s || i_cmd == CMD_STATUS)) begin
          n.cmd = i_cmd;
          n.len = HDR_BITS;
          case (i_cmd)
            CMD_READ: n.sh = {OP_READ_HI, i_addr, 16'h0000};
            CMD_WRITE: begin
              n.sh = {OP_WRITE_HI, i_addr, i_wdata};
              n.len = WRITE_BITS;
            end
            CMD_ENABLE: n.sh = {OP_ENABLE, 8'h00, 16'h0000};
            default: n.sh = {OP_DISABLE, 8'h00, 16'h0000};
          endcase
          if (i_cmd == CMD_STATUS) begin
            n.st = HOST_STAT;
            n.sclk = 1'b0;
          end else begin
            n.st = HOST_LEAD;
            n.sel_n = 1'b0;
          end
        end
      end
      HOST_LEAD: begin
        if (r.ph == LINK_HALF_CYC - 3'h1) begin
          n.st = HOST_SHIFT;
          n.ph = 3'h0;
        end
      end
      HOST_SHIFT: begin
        if (r.ph == 3'h0) begin
          n.sclk = 1'b0;
          n.sdi = r.sh[31];
          n.sh = {r.sh[30:0], 1'b0};
        end else if (r.ph == LINK_HALF_CYC) begin
          n.sclk = 1'b1;
        end else if (r.ph == 3'h7) begin
          n.cnt = 6'(r.cnt + 1'b1);
          if (n.cnt == r.len) begin
            n.cnt = 6'h00;
            n.st = (r.cmd == CMD_READ) ? HOST_RDATA : HOST_GAP;
          end
        end
      end
      HOST_RDATA: begin
        if (r.ph == 3'h0) begin
          n.sclk = 1'b0;
        end else if (r.ph == LINK_HALF_CYC) begin
          n.sclk = 1'b1;
        end else if (r.ph == 3'h7) begin
          n.rdata = {r.rdata[WORD_W-2:0], sdo_s};
          n.cnt = 6'(r.cnt + 1'b1);
          if (n.cnt == WORD_BITS) begin
            n.st = HOST_GAP;
          end
        end
      end
      HOST_STAT: begin
        // select drops one cycle after the clock so the status bit is back through both syncs by phase 7
        if (r.ph == 3'h0) begin
          n.sel_n = 1'b0;
        end else if (r.ph == 3'h7) begin
          n.rdata = {{(WORD_W-1){1'b0}}, sdo_s};
          n.st = HOST_GAP;
        end
      end
      HOST_GAP: begin
        n.gap = 4'(r.gap + 1'b1);
        if (r.gap == 4'h0) begin
          n.done = 1'b1;
        end
        if (r.gap == SEL_GAP_CYC) begin
          n.gap = 4'h0;
          n.st = HOST_IDLE;
        end
      end
      default: begin
        n.st = HOST_IDLE;
      end
    endcase
    if (n.st == HOST_GAP) begin
      n.sel_n = 1'b1;
      n.sclk = 1'b1;
    end
    n.idle = (n.st == HOST_IDLE);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      r <= '0;
      r.sel_n <= 1'b1;
      r.sclk <= 1'b1;
      r.idle <= 1'b1;
      r.rdy <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link.sel_n = r.sel_n;
  assign link.serial_clock_in = r.sclk;
  assign link.serial_data_in = r.sdi;
  assign link.prog_reset = r.prst;
  assign o_idle = r.idle;
  assign o_done = r.done;
  assign o_rdata = r.rdata;
  assign o_link_ready = r.rdy;
endmodule : tsep_host

// >>> design/tsep_if.sv
/*
  Link between host end and memory end: select, serial clock, data in, data out, ready and write reset.
  The data-out wire is resolved here from the device's drive and enable.
*/
`timescale 1ns/1ps
interface tsep_if;
  logic sel_n;
  logic serial_clock_in;
  logic serial_data_in;
  logic prog_reset;
  logic serial_data_out;
  logic serial_data_oe;
  logic ready;
  wire serial_data_line;

  // a released line shows the inverse of the last bit, so a late sample reads wrong
  assign serial_data_line = serial_data_oe ? serial_data_out : ~serial_data_out;

  modport dev (
    input sel_n, serial_clock_in, serial_data_in, prog_reset,
    output serial_data_out, serial_data_oe, ready
  );
  modport host (
    output sel_n, serial_clock_in, serial_data_in, prog_reset,
    input serial_data_line, ready
  );
endinterface : tsep_if

// >>> design/tsep_pkg.sv
/*
  Shared constants, opcodes and state encodings for the three-wire serial word memory port.
  Assumes a 20 MHz system clock on both ends and a link clock made by the host end.
*/
package tsep_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned CLK_FREQ_MHZ = 20;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DEPTH = 1024;
  localparam logic [5:0] HDR_BITS = 6'h10;
  localparam logic [5:0] WRITE_BITS = 6'h20;
  localparam logic [5:0] WORD_BITS = 6'h10;
  localparam logic [5:0] OP_WRITE_HI = 6'h29;
  localparam logic [5:0] OP_READ_HI = 6'h2a;
  localparam logic [7:0] OP_ENABLE = 8'ha3;
  localparam logic [7:0] OP_DISABLE = 8'ha0;
  localparam logic [7:0] OP_FACTORY_FILL = 8'haf;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam int unsigned PROG_TIME_US = 7000;
  localparam int unsigned PROG_CYCLES_DFLT = PROG_TIME_US * CLK_FREQ_MHZ;
  localparam int unsigned PROG_CNT_W = 18;
  localparam int unsigned LINK_HALF_NS = 200;
  localparam logic [2:0] LINK_HALF_CYC = 3'(LINK_HALF_NS / CLK_PERIOD_NS);
  localparam int unsigned SEL_GAP_NS = 250;
  localparam logic [3:0] SEL_GAP_CYC = 4'((SEL_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [3:0] DEV_SYNC_RST = 4'hc;
  localparam logic [1:0] HOST_SYNC_RST = 2'h1;

  typedef enum logic [2:0] {
    DEV_IDLE = 3'h0,
    DEV_STATUS = 3'h1,
    DEV_CMD = 3'h2,
    DEV_READ = 3'h3,
    DEV_HOLD = 3'h4
  } tsep_dev_st_e;

  typedef enum logic [2:0] {
    HOST_IDLE = 3'h0,
    HOST_LEAD = 3'h1,
    HOST_SHIFT = 3'h2,
    HOST_RDATA = 3'h3,
    HOST_STAT = 3'h4,
    HOST_GAP = 3'h5
  } tsep_host_st_e;

  typedef enum logic [2:0] {
    CMD_READ = 3'h0,
    CMD_WRITE = 3'h1,
    CMD_ENABLE = 3'h2,
    CMD_DISABLE = 3'h3,
    CMD_STATUS = 3'h4
  } tsep_cmd_e;
endpackage : tsep_pkg

// >>> design/tsep_sync.sv
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes each bit is a slow level; the first stage is read only by the second.
*/
`timescale 1ns/1ps
module tsep_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // levels
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_r <= RST_VAL;
      o_q <= RST_VAL;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule : tsep_sync

// >>> test/tb_top.sv
/*
  Testbench joining host end and memory end through the link interface; drives host requests.
  Assumes a 20 MHz clock and a programming time of 50 cycles in the memory end.
*/
`timescale 1ns/1ps
module tb_top import tsep_pkg::*;;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_start = 1'b0;
  logic [2:0] i_cmd = 3'h0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [WORD_W-1:0] i_wdata = '0;
  logic i_prog_reset = 1'b0;
  logic o_idle;
  logic o_done;
  logic o_link_ready;
  logic prog_en;
  logic dev_busy;
  logic [WORD_W-1:0] o_rdata;
  logic [15:0] wire_sh = 16'h0;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int wait_n;

  tsep_if link();
  tsep_host u_tsep_host (.i_clk(i_clk), .i_reset(i_reset), .i_start(i_start), .i_cmd(i_cmd), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_prog_reset(i_prog_reset), .o_idle(o_idle), .o_done(o_done), .o_rdata(o_rdata),
    .o_link_ready(o_link_ready), .link(link.host));
  tsep_device #(.PROG_CYCLES(50)) u_tsep_device (.i_clk(i_clk), .i_reset(i_reset), .link(link.dev),
    .o_prog_enabled(prog_en), .o_busy(dev_busy));
  tsep_sva u_tsep_sva (.i_clk(i_clk), .i_reset(i_reset), .sel_n(link.sel_n),
    .serial_clock_in(link.serial_clock_in), .serial_data_in(link.serial_data_in), .prog_reset(link.prog_reset),
    .serial_data_out(link.serial_data_out), .serial_data_oe(link.serial_data_oe), .ready(link.ready));

  always #25 i_clk = ~i_clk;

  // header bits as they cross the wire, sampled on link clock rises
  always @(posedge link.serial_clock_in) begin
    if (!link.sel_n) begin
      wire_sh <= {wire_sh[14:0], link.serial_data_in};
    end
  end

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one host request; waits for idle (and link ready unless status), then for done
  task automatic op(input logic [2:0] cmd, input logic [ADDR_W-1:0] addr, input logic [WORD_W-1:0] data);
    int n;
    n = 0;
    while (!(o_idle === 1'b1 && (o_link_ready === 1'b1 || cmd == 3'h4)) && n < 2000) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    i_start = 1'b1;
    i_cmd = cmd;
    i_addr = addr;
    i_wdata = data;
    @(posedge i_clk);
    #1;
    i_start = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 600) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk("done", {15'h0, o_done}, 16'h1);
  endtask : op

  task automatic stop_test();
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (4) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    chk("dout_idle", {15'h0, link.serial_data_oe}, 16'h0);
    op(3'h4, 10'h0, 16'h0);
    chk("status_ready", o_rdata, 16'h1);
    op(3'h1, 10'h5, 16'h1234);
    op(3'h0, 10'h5, 16'h0);
    chk("write_disabled", o_rdata, 16'h0);
    op(3'h2, 10'h0, 16'h0);
    chk("enable_wire", wire_sh, {OP_ENABLE, 8'h00});
    chk("enabled", {15'h0, prog_en}, 16'h1);
    op(3'h1, 10'h3ff, 16'ha5c3);
    op(3'h4, 10'h0, 16'h0);
    chk("status_busy", o_rdata, 16'h0);
    op(3'h0, 10'h3ff, 16'h0);
    chk("read_top", o_rdata, 16'ha5c3);
    chk("wrap_addr", {6'h00, u_tsep_device.r.addr}, 16'h0000);
    i_prog_reset = 1'b1;
    op(3'h1, 10'h7, 16'hbeef);
    op(3'h0, 10'h3ff, 16'h0);
    chk("read_under_reset", o_rdata, 16'ha5c3);
    op(3'h0, 10'h7, 16'h0);
    chk("write_protected", o_rdata, 16'h0);
    i_prog_reset = 1'b0;
    op(3'h1, 10'h8, 16'h1111);
    repeat (10) @(posedge i_clk);
    #1;
    chk("busy_seen", {15'h0, o_link_ready}, 16'h0);
    chk("dev_busy", {15'h0, dev_busy}, 16'h1);
    i_prog_reset = 1'b1;
    wait_n = 0;
    while (o_link_ready !== 1'b1 && wait_n < 16) begin
      @(posedge i_clk);
      #1;
      wait_n++;
    end
    chk("abort_ready", {15'h0, o_link_ready}, 16'h1);
    chk("abort_busy", {15'h0, dev_busy}, 16'h0);
    i_prog_reset = 1'b0;
    op(3'h0, 10'h8, 16'h0);
    chk("aborted_word", o_rdata, ERASED_WORD);
    op(3'h3, 10'h0, 16'h0);
    chk("disabled", {15'h0, prog_en}, 16'h0);
    op(3'h1, 10'h3ff, 16'h0000);
    op(3'h0, 10'h3ff, 16'h0);
    chk("write_after_disable", o_rdata, 16'ha5c3);
    stop_test();
  end
endmodule : tb_top

// >>> test/tsep_sva.sv
/*
  Link checker for the three-wire serial word port: watches the interface between both ends.
  Assumes both ends run on i_clk and the device is built with a short programming time (50 cycles).
*/
`timescale 1ns/1ps
module tsep_sva (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // link
  input wire logic sel_n,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic prog_reset,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  input wire logic ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  oe_release_a: assert property (sel_n [*6] |-> !serial_data_oe)
    else $error("data out driven while deselected");
  oe_select_a: assert property ($rose(serial_data_oe) |-> !sel_n && !$past(sel_n, 2))
    else $error("data out driven without select");
  abort_ready_a: assert property (prog_reset && !ready |-> ##[1:6] ready)
    else $error("programming not aborted by write reset");
  protect_ready_a: assert property (prog_reset [*8] |-> ready)
    else $error("programming under write reset");
  start_phase_a: assert property ($fell(ready) |-> $past(serial_clock_in, 2) && !prog_reset)
    else $error("programming started off a clock rise");
  busy_len_a: assert property ($fell(ready) |-> ##[1:60] ready)
    else $error("programming too long");
  busy_min_a: assert property ($fell(ready) && !prog_reset |=> !ready [*8])
    else $error("programming too short");
  dout_fall_a: assert property (serial_data_oe && $past(serial_data_oe) && $changed(serial_data_out)
    |-> !$past(serial_clock_in, 2))
    else $error("data out changed off a clock fall");
  busy_quiet_a: assert property (serial_data_oe && !ready && !$past(ready) && !$past(ready, 2)
    |-> !serial_data_out)
    else $error("data out not showing busy");
endmodule : tsep_sva
